// File: include/msit_consts.vh
// Summary of operation
// - Management initialisation ends within 2000 ms
// - Interrupt output low within 200 ms
// - Interrupt released within 500 us of read
// - Normal mode: loss flag within 100 ms
// - Fast mode: loss flag within 1 ms
// - Fast mode: loss status clears within 3 ms
// - Transmit fault flag within 200 ms
// - Other flags set within 200 ms
// - Set mask blocks interrupt within 100 ms
// - Rate change settles within 100 ms
// - Mask and rate timed from stop condition
// - Interrupt released only after all flags read
// - Valid reset pulse restores all settings
// - Deselected module ignores all bus traffic; stop conditions still apply pending masks and rate
`ifndef MSIT_CONSTS_VH
`define MSIT_CONSTS_VH

// Register indices on the management port
`define MSIT_REG_STATUS   4'h0
`define MSIT_REG_LOS_FLAG 4'h1
`define MSIT_REG_TXF_FLAG 4'h2
`define MSIT_REG_GEN_FLAG 4'h3
`define MSIT_REG_LOS_MASK 4'h4
`define MSIT_REG_TXF_MASK 4'h5
`define MSIT_REG_GEN_MASK 4'h6
`define MSIT_REG_CTRL     4'h7
`define MSIT_REG_RATE     4'h8
`define MSIT_REG_LOS_LIVE 4'h9

// Field positions
`define MSIT_STAT_INIT_DONE 0
`define MSIT_STAT_BW_OK     1
`define MSIT_STAT_INT_PIN   2
`define MSIT_CTRL_FAST      0

// Reset values
`define MSIT_RST_FLAG 8'h00
`define MSIT_RST_MASK 8'h00
`define MSIT_RST_CTRL 8'h00
`define MSIT_RST_RATE 8'h00

// Clock rate and printed times
`define MSIT_CLK_KHZ      20000
`define MSIT_INIT_MAX_MS  2000
`define MSIT_RST_MIN_US   2
`define MSIT_LOS_MAX_MS   100
`define MSIT_LOSF_MAX_US  1000
`define MSIT_LOSF_OFF_US  3000
`define MSIT_FLAG_MAX_MS  200
`define MSIT_RATE_MAX_MS  100

`endif

// File: hdl/msit_qual.v
`timescale 1ns/1ps
// Qualifies one slow condition: the output follows the input only after
// the input has held its new level for the programmed number of cycles.
module msit_qual #(
  parameter CW = 22
) (
  input wire clk_i,            // Core clock
  input wire rst_n_i,          // Async reset, active low
  input wire clr_i,            // Soft reset, forces output low
  input wire level_i,          // Synchronised raw condition
  input wire [CW-1:0] set_i,   // Cycles to qualify a rise
  input wire [CW-1:0] off_i,   // Cycles to qualify a fall
  output wire q_o              // Qualified condition
);
  reg [CW-1:0] cnt_q;
  reg q_q;
  wire [CW-1:0] tgt;

  assign tgt = q_q ? off_i : set_i;
  assign q_o = q_q;

  // Count only while input and output disagree; glitches restart the count
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= {CW{1'b0}};
      q_q <= 1'b0;
    end else if (clr_i || (level_i == q_q)) begin
      cnt_q <= {CW{1'b0}};
      q_q <= clr_i ? 1'b0 : q_q;
    end else if (cnt_q + {{(CW-1){1'b0}}, 1'b1} >= tgt) begin
      cnt_q <= {CW{1'b0}};
      q_q <= level_i;
    end else begin
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: hdl/msit_top.v
`timescale 1ns/1ps
`include "msit_consts.vh"
// Soft control and status timing for a pluggable module: flag latching,
// masking, open-drain interrupt, reset and initialisation sequencing.
module msit_top #(
  parameter LANES = 8,
  parameter CW = 22,
  // Every limit is met at half its maximum to leave margin
  parameter INIT_CYC = `MSIT_INIT_MAX_MS * `MSIT_CLK_KHZ / 2,
  parameter LOS_SET_CYC = `MSIT_LOS_MAX_MS * `MSIT_CLK_KHZ / 2,
  parameter LOSF_SET_CYC = `MSIT_LOSF_MAX_US * `MSIT_CLK_KHZ / 2000,
  parameter LOSF_OFF_CYC = `MSIT_LOSF_OFF_US * `MSIT_CLK_KHZ / 2000,
  parameter FLAG_SET_CYC = `MSIT_FLAG_MAX_MS * `MSIT_CLK_KHZ / 2,
  parameter RATE_CYC = `MSIT_RATE_MAX_MS * `MSIT_CLK_KHZ / 2
) (
  input wire REF_CLK_I,              // 20 MHz core clock
  input wire NRST_I,                 // Async reset, active low
  input wire MOD_RESET_N_I,          // Module reset pin, active low
  input wire MOD_SELECT_N_I,         // Module select pin, active low
  input wire SCL_I,                  // Two-wire clock pin level
  input wire SDA_I,                  // Two-wire data pin level
  input wire INT_PIN_I,              // Interrupt wire level read back
  input wire [LANES-1:0] RX_LOS_I,   // Receive loss per lane
  input wire [LANES-1:0] TX_FAULT_I, // Transmit fault per lane
  input wire [LANES-1:0] GEN_COND_I, // Other flag conditions
  input wire [3:0] ADDR_I,           // Register index
  input wire [7:0] WDATA_I,          // Write data
  input wire WR_I,                   // Write strobe
  input wire RD_I,                   // Read strobe
  output wire [7:0] RDATA_O,         // Read data, cycle after strobe
  output wire INT_N_O,               // Interrupt pin drive value
  output wire INT_OE_N_O,            // Interrupt drive enable, low drives
  output wire INIT_DONE_O,           // Management initialisation complete
  output wire [7:0] RATE_SEL_O,      // Rate select applied to optics
  output wire BW_OK_O                // Bandwidth in conformance
);
  localparam RST_MIN_CYC = (`MSIT_RST_MIN_US * `MSIT_CLK_KHZ + 999) / 1000;
  localparam [5:0] RST_MIN = RST_MIN_CYC[5:0];
  localparam [CW-1:0] LOS_SET = LOS_SET_CYC[CW-1:0];
  localparam [CW-1:0] LOSF_SET = LOSF_SET_CYC[CW-1:0];
  localparam [CW-1:0] LOSF_OFF = LOSF_OFF_CYC[CW-1:0];
  localparam [CW-1:0] FLAG_SET = FLAG_SET_CYC[CW-1:0];
  localparam [CW-1:0] RATE_T = RATE_CYC[CW-1:0];
  localparam [25:0] INIT_T = INIT_CYC[25:0];

  // Sticky flag update; a new event beats a clear in the same cycle
  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  // Two-stage synchronisers for every pin input
  reg [3+3*LANES+1:0] s1_q;
  reg [3+3*LANES+1:0] s2_q;
  wire [3+3*LANES+1:0] pins;
  assign pins = {INT_PIN_I, SDA_I, SCL_I, MOD_SELECT_N_I, MOD_RESET_N_I,
                 GEN_COND_I, TX_FAULT_I, RX_LOS_I};
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s1_q <= {5'h1f, {(3*LANES){1'b0}}};
      s2_q <= {5'h1f, {(3*LANES){1'b0}}};
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  wire [LANES-1:0] los_s;
  wire [LANES-1:0] txf_s;
  wire [LANES-1:0] gen_s;
  wire mrst_n_s;
  wire msel_n_s;
  wire scl_s;
  wire sda_s;
  wire ipin_s;
  assign los_s = s2_q[LANES-1:0];
  assign txf_s = s2_q[2*LANES-1:LANES];
  assign gen_s = s2_q[3*LANES-1:2*LANES];
  assign mrst_n_s = s2_q[3*LANES];
  assign msel_n_s = s2_q[3*LANES+1];
  assign scl_s = s2_q[3*LANES+2];
  assign sda_s = s2_q[3*LANES+3];
  assign ipin_s = s2_q[3*LANES+4];

  // Module reset pin: low for the minimum pulse gives a soft reset
  reg [5:0] rlow_q;
  reg soft_q;
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rlow_q <= 6'h00;
      soft_q <= 1'b0;
    end else if (mrst_n_s) begin
      rlow_q <= 6'h00;
      soft_q <= 1'b0;
    end else if (rlow_q + 6'h01 >= RST_MIN) begin
      soft_q <= 1'b1;
    end else begin
      rlow_q <= rlow_q + 6'h01;
    end
  end

  // Initialisation counter, restarted by either reset
  reg [25:0] init_cnt_q;
  reg init_done_q;
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      init_cnt_q <= 26'h000_0000;
      init_done_q <= 1'b0;
    end else if (soft_q) begin
      init_cnt_q <= 26'h000_0000;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      if (init_cnt_q + 26'h000_0001 >= INIT_T) begin
        init_done_q <= 1'b1;
      end else begin
        init_cnt_q <= init_cnt_q + 26'h000_0001;
      end
    end
  end

  // Stop condition on the two-wire pins: data rises while clock is high
  reg sda_d_q;
  wire stop_det;
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sda_d_q <= 1'b1;
    end else begin
      sda_d_q <= sda_s;
    end
  end
  assign stop_det = scl_s & sda_s & ~sda_d_q;

  // Bus access only when selected and initialised
  wire bus_en;
  wire wr_ok;
  wire rd_ok;
  assign bus_en = ~msel_n_s & init_done_q;
  assign wr_ok = WR_I & bus_en;
  assign rd_ok = RD_I & bus_en;

  // Condition qualifiers; the fast loss mode shortens both edges
  reg [7:0] ctrl_q;
  wire fast;
  wire [CW-1:0] los_set;
  wire [CW-1:0] los_off;
  wire [LANES-1:0] los_q;
  wire [LANES-1:0] txf_q;
  wire [LANES-1:0] gen_q;
  assign fast = ctrl_q[`MSIT_CTRL_FAST];
  assign los_set = fast ? LOSF_SET : LOS_SET;
  assign los_off = fast ? LOSF_OFF : LOS_SET;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_qual
      msit_qual #(.CW(CW)) u_los (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .clr_i(soft_q),
        .level_i(los_s[g]),
        .set_i(los_set),
        .off_i(los_off),
        .q_o(los_q[g])
      );
      msit_qual #(.CW(CW)) u_txf (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .clr_i(soft_q),
        .level_i(txf_s[g]),
        .set_i(FLAG_SET),
        .off_i(FLAG_SET),
        .q_o(txf_q[g])
      );
      msit_qual #(.CW(CW)) u_gen (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .clr_i(soft_q),
        .level_i(gen_s[g]),
        .set_i(FLAG_SET),
        .off_i(FLAG_SET),
        .q_o(gen_q[g])
      );
    end
  endgenerate

  // Previous qualified levels; a flag latches on a rising state
  reg [LANES-1:0] los_p_q;
  reg [LANES-1:0] txf_p_q;
  reg [LANES-1:0] gen_p_q;
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      los_p_q <= {LANES{1'b0}};
      txf_p_q <= {LANES{1'b0}};
      gen_p_q <= {LANES{1'b0}};
    end else begin
      los_p_q <= los_q;
      txf_p_q <= txf_q;
      gen_p_q <= gen_q;
    end
  end

  wire [7:0] los_set_ev;
  wire [7:0] txf_set_ev;
  wire [7:0] gen_set_ev;
  assign los_set_ev = init_done_q ? (los_q & ~los_p_q) : 8'h00;
  assign txf_set_ev = init_done_q ? (txf_q & ~txf_p_q) : 8'h00;
  assign gen_set_ev = init_done_q ? (gen_q & ~gen_p_q) : 8'h00;

  // Clear terms: write one to clear, or clear on read of the register
  reg [7:0] los_flag_q;
  reg [7:0] txf_flag_q;
  reg [7:0] gen_flag_q;
  wire [7:0] los_clr;
  wire [7:0] txf_clr;
  wire [7:0] gen_clr;
  assign los_clr = (wr_ok && ADDR_I == `MSIT_REG_LOS_FLAG) ? WDATA_I :
                   (rd_ok && ADDR_I == `MSIT_REG_LOS_FLAG) ? los_flag_q : 8'h00;
  assign txf_clr = (wr_ok && ADDR_I == `MSIT_REG_TXF_FLAG) ? WDATA_I :
                   (rd_ok && ADDR_I == `MSIT_REG_TXF_FLAG) ? txf_flag_q : 8'h00;
  assign gen_clr = (wr_ok && ADDR_I == `MSIT_REG_GEN_FLAG) ? WDATA_I :
                   (rd_ok && ADDR_I == `MSIT_REG_GEN_FLAG) ? gen_flag_q : 8'h00;

  // Sticky flags
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      los_flag_q <= `MSIT_RST_FLAG;
      txf_flag_q <= `MSIT_RST_FLAG;
      gen_flag_q <= `MSIT_RST_FLAG;
    end else if (soft_q) begin
      los_flag_q <= `MSIT_RST_FLAG;
      txf_flag_q <= `MSIT_RST_FLAG;
      gen_flag_q <= `MSIT_RST_FLAG;
    end else begin
      los_flag_q <= flag_next(los_flag_q, los_set_ev, los_clr);
      txf_flag_q <= flag_next(txf_flag_q, txf_set_ev, txf_clr);
      gen_flag_q <= flag_next(gen_flag_q, gen_set_ev, gen_clr);
    end
  end

  // Written masks and rate wait for the stop condition before they act
  reg [7:0] los_mpend_q;
  reg [7:0] txf_mpend_q;
  reg [7:0] gen_mpend_q;
  reg [7:0] los_mask_q;
  reg [7:0] txf_mask_q;
  reg [7:0] gen_mask_q;
  reg [7:0] rate_pend_q;
  reg [7:0] rate_q;
  reg mask_dirty_q;
  reg rate_dirty_q;
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      los_mpend_q <= `MSIT_RST_MASK;
      txf_mpend_q <= `MSIT_RST_MASK;
      gen_mpend_q <= `MSIT_RST_MASK;
      ctrl_q <= `MSIT_RST_CTRL;
      rate_pend_q <= `MSIT_RST_RATE;
      mask_dirty_q <= 1'b0;
      rate_dirty_q <= 1'b0;
    end else if (soft_q) begin
      los_mpend_q <= `MSIT_RST_MASK;
      txf_mpend_q <= `MSIT_RST_MASK;
      gen_mpend_q <= `MSIT_RST_MASK;
      ctrl_q <= `MSIT_RST_CTRL;
      rate_pend_q <= `MSIT_RST_RATE;
      mask_dirty_q <= 1'b0;
      rate_dirty_q <= 1'b0;
    end else begin
      if (wr_ok && ADDR_I == `MSIT_REG_LOS_MASK) begin
        los_mpend_q <= WDATA_I;
      end
      if (wr_ok && ADDR_I == `MSIT_REG_TXF_MASK) begin
        txf_mpend_q <= WDATA_I;
      end
      if (wr_ok && ADDR_I == `MSIT_REG_GEN_MASK) begin
        gen_mpend_q <= WDATA_I;
      end
      if (wr_ok && ADDR_I == `MSIT_REG_CTRL) begin
        ctrl_q <= WDATA_I;
      end
      if (wr_ok && ADDR_I == `MSIT_REG_RATE) begin
        rate_pend_q <= WDATA_I;
      end
      // A write in the stop cycle itself stays pending for the next stop
      if (wr_ok && (ADDR_I == `MSIT_REG_LOS_MASK || ADDR_I == `MSIT_REG_TXF_MASK ||
                    ADDR_I == `MSIT_REG_GEN_MASK)) begin
        mask_dirty_q <= 1'b1;
      end else if (stop_det) begin
        mask_dirty_q <= 1'b0;
      end
      if (wr_ok && ADDR_I == `MSIT_REG_RATE) begin
        rate_dirty_q <= 1'b1;
      end else if (stop_det) begin
        rate_dirty_q <= 1'b0;
      end
    end
  end

  // Active masks follow the pending values at the stop condition
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      los_mask_q <= `MSIT_RST_MASK;
      txf_mask_q <= `MSIT_RST_MASK;
      gen_mask_q <= `MSIT_RST_MASK;
    end else if (soft_q) begin
      los_mask_q <= `MSIT_RST_MASK;
      txf_mask_q <= `MSIT_RST_MASK;
      gen_mask_q <= `MSIT_RST_MASK;
    end else if (stop_det && mask_dirty_q) begin
      los_mask_q <= los_mpend_q;
      txf_mask_q <= txf_mpend_q;
      gen_mask_q <= gen_mpend_q;
    end
  end

  // Rate change: apply at stop, hold bandwidth-ok low while optics settle
  reg [CW-1:0] rate_cnt_q;
  reg bw_ok_q;
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rate_q <= `MSIT_RST_RATE;
      rate_cnt_q <= {CW{1'b0}};
      bw_ok_q <= 1'b1;
    end else if (soft_q) begin
      rate_q <= `MSIT_RST_RATE;
      rate_cnt_q <= {CW{1'b0}};
      bw_ok_q <= 1'b1;
    end else if (stop_det && rate_dirty_q) begin
      rate_q <= rate_pend_q;
      rate_cnt_q <= {CW{1'b0}};
      bw_ok_q <= 1'b0;
    end else if (!bw_ok_q) begin
      if (rate_cnt_q + {{(CW-1){1'b0}}, 1'b1} >= RATE_T) begin
        bw_ok_q <= 1'b1;
      end else begin
        rate_cnt_q <= rate_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Interrupt: any unmasked flag drives the open-drain pin low
  reg int_oe_n_q;
  wire int_req;
  assign int_req = |((los_flag_q & ~los_mask_q) | (txf_flag_q & ~txf_mask_q) |
                     (gen_flag_q & ~gen_mask_q));
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      int_oe_n_q <= 1'b1;
    end else begin
      int_oe_n_q <= ~int_req;
    end
  end

  // Read port; unmapped indices and a deselected module read zero
  reg [7:0] rdata_q;
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 8'h00;
    end else if (rd_ok) begin
      case (ADDR_I)
        `MSIT_REG_STATUS: rdata_q <= {5'h00, ipin_s, bw_ok_q, init_done_q};
        `MSIT_REG_LOS_FLAG: rdata_q <= los_flag_q;
        `MSIT_REG_TXF_FLAG: rdata_q <= txf_flag_q;
        `MSIT_REG_GEN_FLAG: rdata_q <= gen_flag_q;
        `MSIT_REG_LOS_MASK: rdata_q <= los_mpend_q;
        `MSIT_REG_TXF_MASK: rdata_q <= txf_mpend_q;
        `MSIT_REG_GEN_MASK: rdata_q <= gen_mpend_q;
        `MSIT_REG_CTRL: rdata_q <= ctrl_q;
        `MSIT_REG_RATE: rdata_q <= rate_pend_q;
        `MSIT_REG_LOS_LIVE: rdata_q <= los_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign RDATA_O = rdata_q;
  assign INT_N_O = 1'b0;
  assign INT_OE_N_O = int_oe_n_q;
  assign INIT_DONE_O = init_done_q;
  assign RATE_SEL_O = rate_q;
  assign BW_OK_O = bw_ok_q;
endmodule

// File: verification/msit_props.sv
`timescale 1ns/1ps
module msit_props #(
  parameter LANES = 8,
  parameter INIT_CYC = 50,
  parameter RATE_CYC = 25
) (
  input wire REF_CLK_I, // Core clock
  input wire NRST_I, // Async reset, active low
  input wire MOD_RESET_N_I, // Module reset pin
  input wire MOD_SELECT_N_I, // Module select pin
  input wire SCL_I, // Two-wire clock
  input wire SDA_I, // Two-wire data
  input wire INT_PIN_I, // Interrupt wire level
  input wire [LANES-1:0] RX_LOS_I, // Receive loss
  input wire [LANES-1:0] TX_FAULT_I, // Transmit fault
  input wire [LANES-1:0] GEN_COND_I, // Other conditions
  input wire [3:0] ADDR_I, // Register index
  input wire [7:0] WDATA_I, // Write data
  input wire WR_I, // Write strobe
  input wire RD_I, // Read strobe
  input wire [7:0] RDATA_O, // Read data
  input wire INT_N_O, // Interrupt drive value
  input wire INT_OE_N_O, // Interrupt enable, low drives
  input wire INIT_DONE_O, // Initialisation complete
  input wire [7:0] RATE_SEL_O, // Applied rate select
  input wire BW_OK_O // Bandwidth in conformance
);
  localparam int INIT_LIM = INIT_CYC + 8;
  localparam int BW_A = RATE_CYC - 10;
  localparam int BW_B = RATE_CYC - 6;
  logic [15:0] init_cnt_q;

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  // Time spent waiting for initialisation; a held module reset restarts the wait
  always @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      init_cnt_q <= 16'h0000;
    end else if (INIT_DONE_O || !MOD_RESET_N_I) begin
      init_cnt_q <= 16'h0000;
    end else begin
      init_cnt_q <= init_cnt_q + 16'h0001;
    end
  end

  int_drive_a: assert property (INT_N_O == 1'b0)
    else $error("interrupt drive value not low");
  desel_rd_a: assert property ((MOD_SELECT_N_I [*4] ##0 RD_I) |=> RDATA_O == 8'h00)
    else $error("deselected read returned data");
  init_rd_a: assert property ((RD_I && !INIT_DONE_O) |=> RDATA_O == 8'h00)
    else $error("read answered during initialisation");
  init_time_a: assert property (init_cnt_q <= INIT_LIM)
    else $error("initialisation took too long");
  init_early_a: assert property ($rose(INIT_DONE_O) |-> init_cnt_q >= INIT_CYC - 2)
    else $error("initialisation ended too early");
  int_init_a: assert property ((!INIT_DONE_O) [*3] |-> INT_OE_N_O)
    else $error("interrupt asserted while initialising");
  bw_fall_a: assert property (($changed(RATE_SEL_O) && INIT_DONE_O) |-> ##[0:1] !BW_OK_O)
    else $error("rate change without bandwidth settling");
  bw_low_a: assert property ($fell(BW_OK_O) |-> (!BW_OK_O) [*8] ##[BW_A:BW_B] BW_OK_O)
    else $error("bandwidth settling time wrong");
  rate_stop_a: assert property (
    ($changed(RATE_SEL_O) && INIT_DONE_O) |-> $past(SCL_I, 5) && $past(SDA_I, 1))
    else $error("rate applied without a stop condition");

  // Main scenarios reached
  cover property ($fell(INT_OE_N_O));
  cover property ($rose(INT_OE_N_O));
  cover property ($fell(BW_OK_O));
endmodule

bind msit_top msit_props #(.LANES(LANES), .INIT_CYC(INIT_CYC), .RATE_CYC(RATE_CYC)) u_props (
  .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .MOD_RESET_N_I(MOD_RESET_N_I),
  .MOD_SELECT_N_I(MOD_SELECT_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .INT_PIN_I(INT_PIN_I),
  .RX_LOS_I(RX_LOS_I), .TX_FAULT_I(TX_FAULT_I), .GEN_COND_I(GEN_COND_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .INT_N_O(INT_N_O),
  .INT_OE_N_O(INT_OE_N_O), .INIT_DONE_O(INIT_DONE_O), .RATE_SEL_O(RATE_SEL_O),
  .BW_OK_O(BW_OK_O));

// File: verification/msit_host.sv
`timescale 1ns/1ps
module msit_host (
  input wire clk_i, // Host clock, used for pin pulses
  output logic scl_o, // Two-wire clock, pulled up
  output logic sda_o, // Two-wire data, pulled up
  output logic mod_reset_n_o, // Module reset pin
  output logic mod_select_n_o // Module select pin
);
  // Pulled-up lines idle high; module starts selected
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    mod_reset_n_o = 1'b1;
    mod_select_n_o = 1'b0;
  end

  // Short frame closed by a stop; the link clock runs only inside it, off the core phase
  task automatic frame_stop();
    int i;
    #7;
    sda_o = 1'b0;
    #200;
    for (i = 0; i < 4; i++) begin
      scl_o = ~scl_o;
      #200;
    end
    sda_o = 1'b1;
    #200;
  endtask

  // Reset pulse of a chosen length; short ones must be ignored by the module
  task automatic reset_pulse(input int cycles);
    @(posedge clk_i);
    mod_reset_n_o <= 1'b0;
    repeat (cycles) @(posedge clk_i);
    mod_reset_n_o <= 1'b1;
  endtask

  task automatic set_sel(input logic desel);
    @(posedge clk_i);
    mod_select_n_o <= desel;
  endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, nrst, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata, rx_los, tx_flt, gen;
  wire [7:0] rdata, rate_sel;
  wire int_n, int_oe_n, init_done, bw_ok, scl, sda, mrst_n, msel_n, int_pin;
  int miscompares = 0;
  int cmp_count = 0;
  int i;

  // Pull-up on the shared interrupt wire
  assign int_pin = int_oe_n ? 1'b1 : int_n;

  msit_top #(.INIT_CYC(50), .LOS_SET_CYC(20), .LOSF_SET_CYC(5), .LOSF_OFF_CYC(8),
    .FLAG_SET_CYC(30), .RATE_CYC(25)) uut (
    .REF_CLK_I(clk), .NRST_I(nrst), .MOD_RESET_N_I(mrst_n), .MOD_SELECT_N_I(msel_n),
    .SCL_I(scl), .SDA_I(sda), .INT_PIN_I(int_pin), .RX_LOS_I(rx_los), .TX_FAULT_I(tx_flt),
    .GEN_COND_I(gen), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .INT_N_O(int_n), .INT_OE_N_O(int_oe_n), .INIT_DONE_O(init_done),
    .RATE_SEL_O(rate_sel), .BW_OK_O(bw_ok));

  msit_host host (.clk_i(clk), .scl_o(scl), .sda_o(sda), .mod_reset_n_o(mrst_n),
    .mod_select_n_o(msel_n));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk1(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // One-cycle write strobe, then a quiet cycle so strobes never toggle twice at an edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Registered outputs read at the edge still show the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk8(nm, exp, rdata);
  endtask

  // Bounded wait for 0 interrupt enable, 1 init done, 2 bandwidth ok
  task automatic wait_for(input int sel, input logic lvl, input int lim, input string nm);
    logic v;
    int n;
    for (n = 0; n <= lim; n++) begin
      v = (sel == 0) ? int_oe_n : (sel == 1) ? init_done : bw_ok;
      if (v === lvl) break;
      @(posedge clk);
    end
    chk1(nm, lvl, v);
  endtask

  task automatic stop_frame();
    host.frame_stop();
    @(posedge clk);
  endtask

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    rx_los = 8'h00;
    tx_flt = 8'h00;
    gen = 8'h00;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(4'h0, 8'h00, "init_read");
    wait_for(1, 1'b1, 70, "init_done");
    rd_reg(4'h0, 8'h07, "status");
    for (i = 1; i < 10; i++) rd_reg(i[3:0], 8'h00, "reset_value");
    rd_reg(4'hF, 8'h00, "unmapped");
    wr_reg(4'h4, 8'h55);
    rd_reg(4'h4, 8'h55, "mask_rw");
    wr_reg(4'h4, 8'h00);
    // Transmit fault raises, read clears and releases
    tx_flt <= 8'hFE;
    wait_for(0, 1'b0, 45, "int_txf");
    rd_reg(4'h2, 8'hFE, "txf_flag");
    wait_for(0, 1'b1, 3, "int_release");
    rd_reg(4'h2, 8'h00, "txf_cleared");
    tx_flt <= 8'h00;
    // Two sources: release only after both flags read
    rx_los <= 8'hFD;
    gen <= 8'hFF;
    wait_for(0, 1'b0, 30, "int_los");
    repeat (25) @(posedge clk);
    rd_reg(4'h9, 8'hFD, "los_live");
    rd_reg(4'h1, 8'hFD, "los_flag");
    repeat (3) @(posedge clk);
    chk1("int_held", 1'b0, int_oe_n);
    rd_reg(4'h0, 8'h03, "status_int");
    wr_reg(4'h3, 8'h0F);
    rd_reg(4'h3, 8'hF0, "gen_flag");
    wait_for(0, 1'b1, 3, "int_all_read");
    rx_los <= 8'h00;
    gen <= 8'h00;
    // Fast loss mode
    wr_reg(4'h7, 8'h01);
    rx_los <= 8'h02;
    wait_for(0, 1'b0, 12, "int_fast");
    rd_reg(4'h9, 8'h02, "fast_live");
    rx_los <= 8'h00;
    repeat (13) @(posedge clk);
    rd_reg(4'h9, 8'h00, "fast_clear");
    rd_reg(4'h1, 8'h02, "fast_flag");
    wr_reg(4'h7, 8'h00);
    // Masking applied at stop conditions
    wr_reg(4'h5, 8'hFF);
    stop_frame();
    tx_flt <= 8'h01;
    repeat (45) @(posedge clk);
    chk1("int_masked", 1'b1, int_oe_n);
    wr_reg(4'h5, 8'h00);
    repeat (5) @(posedge clk);
    chk1("mask_pending", 1'b1, int_oe_n);
    stop_frame();
    wait_for(0, 1'b0, 4, "int_unmask");
    wr_reg(4'h5, 8'hFF);
    stop_frame();
    wait_for(0, 1'b1, 4, "int_remask");
    rd_reg(4'h2, 8'h01, "masked_flag");
    tx_flt <= 8'h00;
    wr_reg(4'h5, 8'h00);
    stop_frame();
    // Rate select waits for the stop, then settles
    wr_reg(4'h8, 8'h5A);
    repeat (3) @(posedge clk);
    chk8("rate_pending", 8'h00, rate_sel);
    stop_frame();
    repeat (8) @(posedge clk);
    chk8("rate_sel", 8'h5A, rate_sel);
    chk1("bw_settling", 1'b0, bw_ok);
    wait_for(2, 1'b1, 30, "bw_ok");
    rd_reg(4'h0, 8'h07, "status_bw");
    // Deselected module ignores traffic
    host.set_sel(1'b1);
    repeat (4) @(posedge clk);
    wr_reg(4'h4, 8'hAA);
    rd_reg(4'h4, 8'h00, "desel_read");
    host.set_sel(1'b0);
    repeat (3) @(posedge clk);
    rd_reg(4'h4, 8'h00, "desel_write");
    // Short reset pulse ignored, long one restores defaults
    wr_reg(4'h7, 8'h01);
    host.reset_pulse(20);
    repeat (5) @(posedge clk);
    rd_reg(4'h7, 8'h01, "short_reset");
    host.reset_pulse(45);
    chk1("init_restart", 1'b0, init_done);
    wait_for(1, 1'b1, 70, "reinit_done");
    rd_reg(4'h7, 8'h00, "ctrl_default");
    chk8("rate_default", 8'h00, rate_sel);
    stop_test();
  end

  // Hang guard, well beyond the expected run
  initial begin
    #(6000 * 50);
    miscompares++;
    stop_test();
  end
endmodule
